//--- verilog/adc_port_pkg.sv
// package: constants and types for the serial converter control port
// Summary of operation
// - host sends 4-bit channel address msb first, captured on first four rising edges
// - eight command bits load on first eight rising edges; address usable after fourth
// - serial output released while select high, driven while select low
// - select low drives first bit of previous result, msb or lsb first
// - each of the next eleven falling edges drives next bit of previous result
// - eleven remaining result bits shift out, changing only on falling edges
// - sampling starts on fourth falling edge, lasts until last falling edge
// - last falling edge hands conversion to internal conversion controller
// - done output falls after last falling edge, stays low until result ready
// - select high holds bit counters cleared; select falling releases them and enables link
// - select rising stops acceptance of command input and shift clock
package adc_port_pkg;
    localparam int unsigned RESULT_W    = 12;
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned CMD_W       = 8;
    localparam int unsigned CNT_W       = 4;
    localparam int unsigned ADDR_EDGES  = 4;
    localparam int unsigned SAMPLE_EDGE = 4;
    localparam int unsigned LAST_EDGE   = 12;
    localparam int unsigned CMD_ORDER_BIT = 3;
    localparam int unsigned CONV_TIME_NS  = 10000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [ADDR_W-1:0] channel;
        logic [CMD_W-ADDR_W-1:0] options;
    } command_t;

    typedef enum logic [1:0] {
        CONV_IDLE   = 2'b00,
        CONV_RUN    = 2'b01,
        CONV_FINISH = 2'b10
    } conv_state_t;
endpackage : adc_port_pkg

//--- verilog/serial_adc_control_port.sv
// module: serial link front end and conversion controller of the converter
`timescale 1ns/10ps
`default_nettype none
module serial_adc_control_port #(
    parameter int unsigned CONV_CYCLES = adc_port_pkg::CONV_CYCLES
) (
    input  wire logic                                ref_clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                clk_en_i,
    input  wire logic                                sclk_i,
    input  wire logic                                sel_n_i,
    input  wire logic                                cmd_i,
    input  wire logic [adc_port_pkg::RESULT_W-1:0]   conv_data_i,
    output logic                                     dout_o,
    output logic                                     dout_oe_n_o,
    output logic                                     done_o,
    output logic                                     sample_o,
    output logic [adc_port_pkg::ADDR_W-1:0]          mux_addr_o
);
    // --------------------------------------------------------------
    // local types and counts
    // --------------------------------------------------------------
    typedef logic [adc_port_pkg::CNT_W-1:0]    cnt_t;
    typedef logic [adc_port_pkg::RESULT_W-1:0] word_t;
    typedef logic [31:0]                       conv_cnt_t;

    localparam cnt_t      CMD_EDGES   = cnt_t'(adc_port_pkg::CMD_W);
    localparam cnt_t      ADDR_LAST   = cnt_t'(adc_port_pkg::ADDR_EDGES - 1);
    localparam cnt_t      ADDR_SEEN   = cnt_t'(adc_port_pkg::ADDR_EDGES);
    localparam cnt_t      SAMPLE_LAST = cnt_t'(adc_port_pkg::SAMPLE_EDGE - 1);
    localparam cnt_t      FALL_EDGES  = cnt_t'(adc_port_pkg::LAST_EDGE);
    localparam cnt_t      FALL_LAST   = cnt_t'(adc_port_pkg::LAST_EDGE - 1);
    localparam conv_cnt_t CONV_LAST   = conv_cnt_t'(CONV_CYCLES - 1);

    // --------------------------------------------------------------
    // link domain: state clocked by the shift clock
    // --------------------------------------------------------------
    cnt_t                            rise_cnt_reg;
    cnt_t                            fall_cnt_reg;
    logic [adc_port_pkg::CMD_W-1:0]  cmd_shift_reg;
    logic [adc_port_pkg::ADDR_W-1:0] addr_hold_reg;
    logic                            lsb_first_reg;
    logic                            sample_tgl_reg;
    logic                            start_tgl_reg;
    cnt_t                            bit_pos;
    logic                            dout_bit;
    word_t                           result_reg;

    // rising edge count, cleared while select is high
    always_ff @(posedge sclk_i or posedge sel_n_i) begin
        if (sel_n_i) begin
            rise_cnt_reg <= '0;
        end else if (rise_cnt_reg < CMD_EDGES) begin
            rise_cnt_reg <= rise_cnt_reg + cnt_t'(1);
        end
    end

    // command shifter: eight bits, msb first
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_shift_reg <= '0;
        end else if (!sel_n_i && rise_cnt_reg < CMD_EDGES) begin
            cmd_shift_reg <= {cmd_shift_reg[adc_port_pkg::CMD_W-2:0], cmd_i};
        end
    end

    // address frozen at the fourth rising edge, stable for the system side
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_hold_reg <= '0;
        end else if (!sel_n_i && rise_cnt_reg == ADDR_LAST) begin
            addr_hold_reg <= {cmd_shift_reg[adc_port_pkg::ADDR_W-2:0], cmd_i};
        end
    end

    // falling edge count, cleared while select is high
    always_ff @(negedge sclk_i or posedge sel_n_i) begin
        if (sel_n_i) begin
            fall_cnt_reg <= '0;
        end else if (fall_cnt_reg < FALL_EDGES) begin
            fall_cnt_reg <= fall_cnt_reg + cnt_t'(1);
        end
    end

    // bit order for the next transfer, taken from the complete command
    always_ff @(negedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            lsb_first_reg <= 1'b0;
        end else if (!sel_n_i && fall_cnt_reg == FALL_LAST) begin
            lsb_first_reg <= cmd_shift_reg[adc_port_pkg::CMD_ORDER_BIT];
        end
    end

    // sampling window toggles at its opening and closing edge
    always_ff @(negedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_tgl_reg <= 1'b0;
        end else if (!sel_n_i && (fall_cnt_reg == SAMPLE_LAST || fall_cnt_reg == FALL_LAST)) begin
            sample_tgl_reg <= ~sample_tgl_reg;
        end
    end

    // handover to the conversion controller on the last falling edge
    always_ff @(negedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            start_tgl_reg <= 1'b0;
        end else if (!sel_n_i && fall_cnt_reg == FALL_LAST) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    // result bit picked by the falling edge count; result is stable during a transfer
    always_comb begin
        bit_pos = '0;
        if (fall_cnt_reg < FALL_EDGES) begin
            bit_pos = fall_cnt_reg;
        end
        if (lsb_first_reg) begin
            dout_bit = result_reg[bit_pos];
        end else begin
            dout_bit = result_reg[FALL_LAST - bit_pos];
        end
    end

    // --------------------------------------------------------------
    // system domain: synchronisers
    // --------------------------------------------------------------
    logic [1:0] sel_sync_reg;
    logic [1:0] start_sync_reg;
    logic [1:0] sample_sync_reg;
    logic [1:0] dout_sync_reg;
    cnt_t       rise_sync0_reg;
    cnt_t       rise_sync1_reg;
    cnt_t       rise_sync2_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_sync_reg <= 2'h3;
        end else if (clk_en_i) begin
            sel_sync_reg <= {sel_sync_reg[0], sel_n_i};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_sync_reg <= 2'h0;
        end else if (clk_en_i) begin
            dout_sync_reg <= {dout_sync_reg[0], dout_bit};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_sync_reg <= 2'h0;
        end else if (clk_en_i) begin
            start_sync_reg <= {start_sync_reg[0], start_tgl_reg};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_sync_reg <= 2'h0;
        end else if (clk_en_i) begin
            sample_sync_reg <= {sample_sync_reg[0], sample_tgl_reg};
        end
    end

    // count crosses as a bus; a third stage lets the next compare two settled copies
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rise_sync0_reg <= '0;
            rise_sync1_reg <= '0;
            rise_sync2_reg <= '0;
        end else if (clk_en_i) begin
            rise_sync0_reg <= rise_cnt_reg;
            rise_sync1_reg <= rise_sync0_reg;
            rise_sync2_reg <= rise_sync1_reg;
        end
    end

    // --------------------------------------------------------------
    // pins: output enable, serial data and multiplexer address
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_oe_n_o <= 1'b1;
        end else if (clk_en_i) begin
            dout_oe_n_o <= sel_sync_reg[1];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_o <= 1'b0;
        end else if (clk_en_i) begin
            dout_o <= dout_sync_reg[1];
        end
    end

    // address is taken only once the count has settled past the fourth edge
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mux_addr_o <= '0;
        end else if (clk_en_i) begin
            if (!sel_sync_reg[1] && rise_sync2_reg == rise_sync1_reg && rise_sync1_reg >= ADDR_SEEN) begin
                mux_addr_o <= addr_hold_reg;
            end
        end
    end

    // --------------------------------------------------------------
    // conversion controller
    // --------------------------------------------------------------
    adc_port_pkg::conv_state_t state_reg;
    conv_cnt_t                 conv_cnt_reg;
    logic                      start_seen_reg;
    logic                      sample_seen_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_seen_reg <= 1'b0;
        end else if (clk_en_i) begin
            start_seen_reg <= start_sync_reg[1];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_seen_reg <= 1'b0;
        end else if (clk_en_i) begin
            sample_seen_reg <= sample_sync_reg[1];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_o <= 1'b0;
        end else if (clk_en_i) begin
            if (sample_seen_reg != sample_sync_reg[1]) begin
                sample_o <= ~sample_o;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg    <= adc_port_pkg::CONV_IDLE;
            conv_cnt_reg <= '0;
            done_o       <= 1'b1;
            result_reg   <= '0;
        end else if (clk_en_i) begin
            case (state_reg)
                adc_port_pkg::CONV_IDLE: begin
                    if (start_seen_reg != start_sync_reg[1]) begin
                        state_reg    <= adc_port_pkg::CONV_RUN;
                        conv_cnt_reg <= '0;
                        done_o       <= 1'b0;
                    end
                end
                adc_port_pkg::CONV_RUN: begin
                    if (conv_cnt_reg >= CONV_LAST) begin
                        state_reg <= adc_port_pkg::CONV_FINISH;
                    end else begin
                        conv_cnt_reg <= conv_cnt_reg + conv_cnt_t'(1);
                    end
                end
                adc_port_pkg::CONV_FINISH: begin
                    result_reg <= conv_data_i;
                    done_o     <= 1'b1;
                    state_reg  <= adc_port_pkg::CONV_IDLE;
                end
                default: begin
                    state_reg <= adc_port_pkg::CONV_IDLE;
                end
            endcase
        end
    end
endmodule : serial_adc_control_port
`default_nettype wire

//--- verification/serial_adc_control_port_props.sv
// checker: timing relations at the converter port pins
`timescale 1ns/10ps
`default_nettype none
module serial_adc_control_port_props #(
    parameter int unsigned CONV_CYCLES = 20
) (
    input wire logic                                ref_clk_i,
    input wire logic                                rst_i,
    input wire logic                                sclk_i,
    input wire logic                                sel_n_i,
    input wire logic                                dout_o,
    input wire logic                                dout_oe_n_o,
    input wire logic                                done_o,
    input wire logic                                sample_o,
    input wire logic [adc_port_pkg::ADDR_W-1:0]     mux_addr_o
);
    localparam int CMAX = CONV_CYCLES + 8;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_win; sample_o [*8]; endsequence
    property p_off; sel_n_i [*5] |-> dout_oe_n_o; endproperty
    a_off: assert property (p_off) else $error("output driven while deselected");
    property p_on; !sel_n_i [*5] |-> !dout_oe_n_o; endproperty
    a_on: assert property (p_on) else $error("output released while selected");
    property p_chg; $changed(dout_o) && !dout_oe_n_o && $past(!dout_oe_n_o) |-> !sclk_i; endproperty
    a_chg: assert property (p_chg) else $error("result bit moved while shift clock high");
    property p_done; $fell(sample_o) |-> ##[0:8] !done_o; endproperty
    a_done: assert property (p_done) else $error("done stayed high after last edge");
    property p_hold; $fell(done_o) |-> !done_o [*8]; endproperty
    a_hold: assert property (p_hold) else $error("done returned high too early");
    property p_end; $fell(done_o) |-> ##[1:CMAX] done_o; endproperty
    a_end: assert property (p_end) else $error("conversion never finished");
    property p_win; $rose(sample_o) |-> done_o ##0 s_win; endproperty
    a_win: assert property (p_win) else $error("sampling window cut short");
    property p_addr; $changed(mux_addr_o) |-> ##[1:24] $rose(sample_o); endproperty
    a_addr: assert property (p_addr) else $error("sampling did not follow address");
    property p_samp; sample_o |-> !dout_oe_n_o; endproperty
    a_samp: assert property (p_samp) else $error("sampling outside a transfer");
endmodule : serial_adc_control_port_props
bind serial_adc_control_port serial_adc_control_port_props #(.CONV_CYCLES(CONV_CYCLES)) props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sel_n_i(sel_n_i), .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o), .done_o(done_o), .sample_o(sample_o), .mux_addr_o(mux_addr_o));
`default_nettype wire

//--- verification/adc_host_model.sv
// partner: host serial port driving select, shift clock and command
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      cmd_o,
    input  wire logic dout_i,
    input  wire logic dout_oe_n_i
);
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        cmd_o = 1'b0;
    end
    task automatic xfer(input adc_port_pkg::command_t c, output logic [11:0] r);
        sel_n_o = 1'b0;
        cmd_o = c[7];
        #37;
        for (int k = 0; k < 12; k++) begin
            #40 sclk_o = 1'b1;
            // a released line shows the inverse, never a held value
            r = {r[10:0], dout_oe_n_i ? ~dout_i : dout_i};
            #40 sclk_o = 1'b0;
            cmd_o = (k < 7) ? c[6-k] : ~cmd_o;
        end
        #40 sel_n_o = 1'b1;
        #20;
    endtask : xfer
endmodule : adc_host_model
`default_nettype wire

//--- verification/serial_adc_control_port_test.sv
// testbench: random and corner transfers through the host port model
`timescale 1ns/10ps
`default_nettype none
module serial_adc_control_port_test;
    logic                   ref_clk_i   = 1'b0;
    logic                   rst_i       = 1'b1;
    logic                   clk_en_i    = 1'b1;
    logic [11:0]            conv_data_i = 12'h000;
    wire logic              sclk, sel_n, cmd, dout_o, dout_oe_n_o, done_o, sample_o;
    wire logic [3:0]        mux_addr_o;
    int                     error_cnt   = 0;
    int                     check_count = 0;
    logic [11:0]            prev, got;
    adc_port_pkg::command_t c;
    always #2.5 ref_clk_i = ~ref_clk_i;
    serial_adc_control_port #(.CONV_CYCLES(20)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
        .sclk_i(sclk), .sel_n_i(sel_n), .cmd_i(cmd), .conv_data_i(conv_data_i), .dout_o(dout_o),
        .dout_oe_n_o(dout_oe_n_o), .done_o(done_o), .sample_o(sample_o), .mux_addr_o(mux_addr_o));
    adc_host_model host (.sclk_o(sclk), .sel_n_o(sel_n), .cmd_o(cmd), .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o));
    function automatic logic [11:0] expect_bits(logic [11:0] d, logic lsb);
        logic [11:0] r;
        for (int k = 0; k < 12; k++) r[k] = lsb ? d[11-k] : d[k];
        return r;
    endfunction : expect_bits
    task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic wait_done(logic lvl);
        int n;
        for (n = 0; n < 200 && done_o !== lvl; n++) @(posedge ref_clk_i);
        if (n == 200) begin
            error_cnt++;
            finish_test();
        end
    endtask : wait_done
    initial begin
        void'($urandom(27));
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        for (int i = 0; i < 8; i++) begin
            c.channel = (i == 0) ? 4'hf : (i == 4) ? 4'h0 : 4'($urandom());
            c.options = {i >= 4, 3'($urandom())};
            @(posedge ref_clk_i);
            conv_data_i <= (i == 1) ? 12'h801 : 12'($urandom());
            host.xfer(c, got);
            // the first transfer of each bit order carries an older order
            if (i % 4 != 0) check("result", got, expect_bits(prev, c.options[3]));
            check("channel", 12'(mux_addr_o), 12'(c.channel));
            wait_done(1'b0);
            check("done low", 12'(done_o), 12'h000);
            check("sample off", 12'(sample_o), 12'h000);
            check("select off", 12'(dout_oe_n_o), 12'h001);
            wait_done(1'b1);
            prev = conv_data_i;
            $display("transfer %0d done", i);
        end
        finish_test();
    end
endmodule : serial_adc_control_port_test
`default_nettype wire
